// ===== ssp_pkg.sv
// Shared constants and types of serial port zero: register map, control
// fields, pin carrier and serial timing.
// Assumes a single 10 MHz system clock domain for all users of the package.
package ssp_pkg;

  // ==========================================================================
  // Register bus
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  localparam logic [ADDR_W-1:0] REG_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_DIV   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PCTL  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_PDIR  = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_PDAT  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STAT  = 8'h14;
  localparam logic [ADDR_W-1:0] REG_RXD   = 8'h18;
  localparam logic [ADDR_W-1:0] REG_TX1   = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_TX2   = 8'h20;

  // ==========================================================================
  // Control register fields
  localparam int unsigned CTRL_W      = 10;
  localparam int unsigned CB_SYNC     = 0;
  localparam int unsigned CB_CLK_OUT  = 1;
  localparam int unsigned CB_FS_OUT   = 2;
  localparam int unsigned CB_A_OUT    = 3;
  localparam int unsigned CB_B_OUT    = 4;
  localparam int unsigned CB_A_FLAG   = 5;
  localparam int unsigned CB_B_FLAG   = 6;
  localparam int unsigned CB_EN       = 7;
  localparam int unsigned CB_FLAG0    = 8;
  localparam int unsigned CB_FLAG1    = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

  localparam int unsigned ST_FULL = 0;
  localparam int unsigned ST_OVR  = 1;

  // ==========================================================================
  // Pins
  localparam int unsigned PIN_W   = 5;
  localparam int unsigned PIN_A   = 0;
  localparam int unsigned PIN_B   = 1;
  localparam int unsigned PIN_C   = 2;
  localparam int unsigned PIN_CLK = 3;
  localparam int unsigned PIN_RXD = 4;
  localparam logic [PIN_W-1:0] PIN_RST = 5'h00;

  typedef struct packed {
    logic serial_rx_data_pin;
    logic serial_bit_clock_pin;
    logic serial_ctrl_line_c;
    logic serial_ctrl_line_b;
    logic serial_ctrl_line_a;
  } ssp_pins_t;

  // ==========================================================================
  // Serial timing
  localparam int unsigned WORD_LEN         = 8;
  localparam int unsigned BCLK_MIN_PERIOD_T = 6;
  localparam logic [7:0]  MIN_HALF_CYC     = 8'(BCLK_MIN_PERIOD_T / 2);
  localparam logic [7:0]  DIV_RST          = 8'h04;
  localparam logic [2:0]  WL_LAST          = 3'(WORD_LEN - 1);

  typedef enum logic {
    RX_IDLE  = 1'b0,
    RX_SHIFT = 1'b1
  } ssp_rx_st_t;

endpackage : ssp_pkg

// ===== ssp_pin_sync.sv
// Two-flop synchroniser for the serial port pins, with a third stage for
// edge detection.
// Assumes pin levels arrive asynchronously to clock_in.
`timescale 1ns/1ps
module ssp_pin_sync
  import ssp_pkg::*;
(
  input  wire logic             clock_in,
  input  wire logic             sys_rst_in,
  input  wire logic [PIN_W-1:0] async_in,
  output logic      [PIN_W-1:0] level_out,
  output logic      [PIN_W-1:0] rise_out,
  output logic      [PIN_W-1:0] fall_out
);

  logic [PIN_W-1:0] meta_ff;
  logic [PIN_W-1:0] stable_ff;
  logic [PIN_W-1:0] last_ff;

  // ==========================================================================
  // Stages; only the second and third stages are looked at
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      meta_ff   <= PIN_RST;
      stable_ff <= PIN_RST;
      last_ff   <= PIN_RST;
    end
    else
    begin
      meta_ff   <= async_in;
      stable_ff <= meta_ff;
      last_ff   <= stable_ff;
    end
  end

  always_comb
  begin
    level_out = stable_ff;
    rise_out  = stable_ff & ~last_ff;
    fall_out  = ~stable_ff & last_ff;
  end

endmodule : ssp_pin_sync

// ===== ssp_port0.sv
// Pin-level logic of synchronous serial port zero: pin multiplexing with
// general-purpose port, bit clock and frame sync handling, two transmit
// outputs on the control lines and a receive shifter.
// Assumes a word-wide register port on clock_in and pins outside the domain.
//
// Operation
// R1 - Line c carries shared frame sync in sync mode, transmit-only in async.
// R2 - Line c as output drives internal frame sync; as input takes external.
// R3 - Line a: receive clock in async; transmitter 1 output or flag 0 in sync.
// R4 - Line b: receive frame sync in async; transmitter 2 or flag 1 in sync.
// R5 - Bit clock in or out; clocks both sides in sync, transmitter in async.
// R6 - External bit clock period above 6T; each half at least three cycles.
// R7 - Receive data pin is an input; bits shift into the receive shifter.
// R8 - Pins reset to port inputs; direction per pin; control selects serial use.
// R9 - In stop, inputs ignored and output levels kept.
// R10 - Wait state leaves every pin level and direction unchanged.
// R11 - External bit clock and frame sync are synchronised before use.
`timescale 1ns/1ps
module ssp_port0
  import ssp_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              sys_rst_in,
  input  wire logic              stop_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  input  wire ssp_pins_t         pin_in,
  output ssp_pins_t              pin_out,
  output ssp_pins_t              pin_oe_out
);

  // ==========================================================================
  // Pin synchroniser
  logic [PIN_W-1:0] sy_lvl;
  logic [PIN_W-1:0] sy_rise;
  logic [PIN_W-1:0] sy_fall;

  ssp_pin_sync u_sync (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (pin_in),   // R11
    .level_out  (sy_lvl),
    .rise_out   (sy_rise),
    .fall_out   (sy_fall)
  );

  // ==========================================================================
  // Register file
  logic [CTRL_W-1:0]   ctrl_ff,   nxt_ctrl;
  logic [7:0]          div_ff,    nxt_div;
  logic [PIN_W-1:0]    pctl_ff,   nxt_pctl;
  logic [PIN_W-1:0]    pdir_ff,   nxt_pdir;
  logic [PIN_W-1:0]    pdat_ff,   nxt_pdat;
  logic [WORD_LEN-1:0] tx1_ff,    nxt_tx1;
  logic [WORD_LEN-1:0] tx2_ff,    nxt_tx2;
  logic [WORD_LEN-1:0] rxw_ff,    nxt_rxw;
  logic                full_ff,   nxt_full;
  logic                ovr_ff,    nxt_ovr;
  logic [DATA_W-1:0]   rdata_ff,  nxt_rdata;
  logic [PIN_W-1:0]    plvl_ff,   nxt_plvl;
  logic                rx_done;
  logic [WORD_LEN-1:0] rx_word;

  always_comb
  begin
    nxt_ctrl  = ctrl_ff;
    nxt_div   = div_ff;
    nxt_pctl  = pctl_ff;
    nxt_pdir  = pdir_ff;
    nxt_pdat  = pdat_ff;
    nxt_tx1   = tx1_ff;
    nxt_tx2   = tx2_ff;
    nxt_rxw   = rxw_ff;
    nxt_full  = full_ff;
    nxt_ovr   = ovr_ff;
    nxt_rdata = '0;
    // Stopped inputs are ignored: the sampled levels hold their last value
    nxt_plvl  = stop_in ? plvl_ff : sy_lvl; // R9
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        REG_CTRL: nxt_ctrl = reg_wdata_in[CTRL_W-1:0];
        REG_DIV:  nxt_div  = reg_wdata_in[7:0];
        REG_PCTL: nxt_pctl = reg_wdata_in[PIN_W-1:0]; // R8
        REG_PDIR: nxt_pdir = reg_wdata_in[PIN_W-1:0]; // R8
        REG_PDAT: nxt_pdat = reg_wdata_in[PIN_W-1:0];
        REG_STAT: if (reg_wdata_in[ST_OVR]) nxt_ovr = 1'b0;
        REG_TX1:  nxt_tx1  = reg_wdata_in[WORD_LEN-1:0];
        REG_TX2:  nxt_tx2  = reg_wdata_in[WORD_LEN-1:0];
        default:  ;
      endcase
    end
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        REG_CTRL: nxt_rdata = DATA_W'(ctrl_ff);
        REG_DIV:  nxt_rdata = DATA_W'(div_ff);
        REG_PCTL: nxt_rdata = DATA_W'(pctl_ff);
        REG_PDIR: nxt_rdata = DATA_W'(pdir_ff);
        REG_PDAT: nxt_rdata = DATA_W'(plvl_ff);
        REG_STAT: nxt_rdata = DATA_W'({ovr_ff, full_ff});
        REG_RXD:  nxt_rdata = DATA_W'(rxw_ff);
        REG_TX1:  nxt_rdata = DATA_W'(tx1_ff);
        REG_TX2:  nxt_rdata = DATA_W'(tx2_ff);
        default:  nxt_rdata = '0;
      endcase
      if (reg_addr_in == REG_RXD)
        nxt_full = 1'b0;
    end
    // A word landing in the same cycle as the read keeps the flag set
    if (rx_done)
    begin
      nxt_rxw  = rx_word;
      nxt_full = 1'b1;
      if (full_ff && !(reg_rd_in && reg_addr_in == REG_RXD))
        nxt_ovr = 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_ff  <= CTRL_RST;
      div_ff   <= DIV_RST;
      pctl_ff  <= PIN_RST; // R8
      pdir_ff  <= PIN_RST; // R8
      pdat_ff  <= PIN_RST;
      tx1_ff   <= '0;
      tx2_ff   <= '0;
      rxw_ff   <= '0;
      full_ff  <= 1'b0;
      ovr_ff   <= 1'b0;
      rdata_ff <= '0;
      plvl_ff  <= PIN_RST;
    end
    else
    begin
      ctrl_ff  <= nxt_ctrl;
      div_ff   <= nxt_div;
      pctl_ff  <= nxt_pctl;
      pdir_ff  <= nxt_pdir;
      pdat_ff  <= nxt_pdat;
      tx1_ff   <= nxt_tx1;
      tx2_ff   <= nxt_tx2;
      rxw_ff   <= nxt_rxw;
      full_ff  <= nxt_full;
      ovr_ff   <= nxt_ovr;
      rdata_ff <= nxt_rdata;
      plvl_ff  <= nxt_plvl;
    end
  end

  assign reg_rdata_out = rdata_ff;

  // ==========================================================================
  // Clock and frame sync selection
  logic sync_mode;
  logic enable;
  logic [7:0] half_cyc;

  assign sync_mode = ctrl_ff[CB_SYNC];
  assign enable    = ctrl_ff[CB_EN] & ~stop_in;
  // Internal clock never runs faster than the receive logic can follow
  assign half_cyc  = (div_ff < MIN_HALF_CYC) ? MIN_HALF_CYC : div_ff; // R6

  logic [7:0]          dcnt_ff,  nxt_dcnt;
  logic                gclk_ff,  nxt_gclk;
  logic [2:0]          bcnt_ff,  nxt_bcnt;
  logic                fsg_ff,   nxt_fsg;
  logic [WORD_LEN-1:0] sh1_ff,   nxt_sh1;
  logic [WORD_LEN-1:0] sh2_ff,   nxt_sh2;
  logic                t1_ff,    nxt_t1;
  logic                t2_ff,    nxt_t2;
  logic [2:0]          tcnt_ff,  nxt_tcnt;
  ssp_rx_st_t          rst_ff,   nxt_rst;
  logic [WORD_LEN-1:0] rsh_ff,   nxt_rsh;
  logic [2:0]          rcnt_ff,  nxt_rcnt;
  logic                g_rise, g_fall;
  logic                t_rise, t_fall, r_rise, r_fall;
  logic                t_fs, r_fs;

  always_comb
  begin
    g_rise = 1'b0;
    g_fall = 1'b0;
    if (enable && dcnt_ff >= half_cyc - 8'h01)
    begin
      g_rise = ~gclk_ff;
      g_fall = gclk_ff;
    end
    // Bit clock: own divider when driven, synchronised pin otherwise
    t_rise = ctrl_ff[CB_CLK_OUT] ? g_rise : sy_rise[PIN_CLK]; // R5 R11
    t_fall = ctrl_ff[CB_CLK_OUT] ? g_fall : sy_fall[PIN_CLK]; // R5 R11
    t_fs   = ctrl_ff[CB_FS_OUT]  ? fsg_ff : sy_lvl[PIN_C];    // R2 R11
    if (sync_mode)
    begin
      r_rise = t_rise; // R5
      r_fall = t_fall; // R5
      r_fs   = t_fs;   // R1
    end
    else
    begin
      r_rise = ctrl_ff[CB_A_OUT] ? g_rise : sy_rise[PIN_A]; // R3
      r_fall = ctrl_ff[CB_A_OUT] ? g_fall : sy_fall[PIN_A]; // R3
      r_fs   = ctrl_ff[CB_B_OUT] ? fsg_ff : sy_lvl[PIN_B];  // R4
    end
  end

  // ==========================================================================
  // Serial engine, frozen while stopped
  always_comb
  begin
    nxt_dcnt = dcnt_ff;
    nxt_gclk = gclk_ff;
    nxt_bcnt = bcnt_ff;
    nxt_fsg  = fsg_ff;
    nxt_sh1  = sh1_ff;
    nxt_sh2  = sh2_ff;
    nxt_t1   = t1_ff;
    nxt_t2   = t2_ff;
    nxt_tcnt = tcnt_ff;
    nxt_rst  = rst_ff;
    nxt_rsh  = rsh_ff;
    nxt_rcnt = rcnt_ff;
    rx_done  = 1'b0;
    rx_word  = rsh_ff;
    if (enable)
    begin
      if (g_rise || g_fall)
      begin
        nxt_dcnt = '0;
        nxt_gclk = ~gclk_ff;
      end
      else
        nxt_dcnt = dcnt_ff + 8'h01;
      // Frame sync spans the bit period before each word's first bit
      if (t_fall)
      begin
        nxt_bcnt = (bcnt_ff == WL_LAST) ? 3'h0 : bcnt_ff + 3'h1;
        nxt_fsg  = (nxt_bcnt == WL_LAST);
      end
      if (t_rise)
      begin
        if (t_fs)
        begin
          nxt_t1   = tx1_ff[WORD_LEN-1];
          nxt_t2   = tx2_ff[WORD_LEN-1];
          nxt_sh1  = {tx1_ff[WORD_LEN-2:0], 1'b0};
          nxt_sh2  = {tx2_ff[WORD_LEN-2:0], 1'b0};
          nxt_tcnt = WL_LAST;
        end
        else if (tcnt_ff != 3'h0)
        begin
          nxt_t1   = sh1_ff[WORD_LEN-1];
          nxt_t2   = sh2_ff[WORD_LEN-1];
          nxt_sh1  = {sh1_ff[WORD_LEN-2:0], 1'b0};
          nxt_sh2  = {sh2_ff[WORD_LEN-2:0], 1'b0};
          nxt_tcnt = tcnt_ff - 3'h1;
        end
        else
        begin
          nxt_t1 = 1'b0;
          nxt_t2 = 1'b0;
        end
      end
      if (pctl_ff[PIN_RXD])
      begin
        if (r_rise && r_fs)
        begin
          nxt_rst  = RX_SHIFT;
          nxt_rcnt = '0;
        end
        else if (r_fall && rst_ff == RX_SHIFT)
        begin
          nxt_rsh  = {rsh_ff[WORD_LEN-2:0], sy_lvl[PIN_RXD]}; // R7
          nxt_rcnt = rcnt_ff + 3'h1;
          if (rcnt_ff == WL_LAST)
          begin
            nxt_rst = RX_IDLE;
            rx_done = 1'b1;
            rx_word = nxt_rsh;
          end
        end
      end
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      dcnt_ff <= '0;
      gclk_ff <= 1'b0;
      bcnt_ff <= '0;
      fsg_ff  <= 1'b0;
      sh1_ff  <= '0;
      sh2_ff  <= '0;
      t1_ff   <= 1'b0;
      t2_ff   <= 1'b0;
      tcnt_ff <= '0;
      rst_ff  <= RX_IDLE;
      rsh_ff  <= '0;
      rcnt_ff <= '0;
    end
    else
    begin
      dcnt_ff <= nxt_dcnt;
      gclk_ff <= nxt_gclk;
      bcnt_ff <= nxt_bcnt;
      fsg_ff  <= nxt_fsg;
      sh1_ff  <= nxt_sh1;
      sh2_ff  <= nxt_sh2;
      t1_ff   <= nxt_t1;
      t2_ff   <= nxt_t2;
      tcnt_ff <= nxt_tcnt;
      rst_ff  <= nxt_rst;
      rsh_ff  <= nxt_rsh;
      rcnt_ff <= nxt_rcnt;
    end
  end

  // ==========================================================================
  // Pin multiplexer. Only stop holds the pins; there is no wait input, so
  // a wait state cannot move any level or direction.
  logic [PIN_W-1:0] pout_ff, nxt_pout;
  logic [PIN_W-1:0] poe_ff,  nxt_poe;
  logic [PIN_W-1:0] s_out,   s_oe;

  always_comb
  begin
    s_out = '0;
    s_oe  = '0;
    if (sync_mode)
    begin
      s_oe[PIN_A]  = 1'b1;                                          // R3
      s_out[PIN_A] = ctrl_ff[CB_A_FLAG] ? ctrl_ff[CB_FLAG0] : t1_ff; // R3
      s_oe[PIN_B]  = 1'b1;                                          // R4
      s_out[PIN_B] = ctrl_ff[CB_B_FLAG] ? ctrl_ff[CB_FLAG1] : t2_ff; // R4
    end
    else
    begin
      s_oe[PIN_A]  = ctrl_ff[CB_A_OUT]; // R3
      s_out[PIN_A] = gclk_ff;
      s_oe[PIN_B]  = ctrl_ff[CB_B_OUT]; // R4
      s_out[PIN_B] = fsg_ff;
    end
    s_oe[PIN_C]    = ctrl_ff[CB_FS_OUT];  // R2
    s_out[PIN_C]   = fsg_ff;              // R2
    s_oe[PIN_CLK]  = ctrl_ff[CB_CLK_OUT]; // R5
    s_out[PIN_CLK] = gclk_ff;             // R5
    s_oe[PIN_RXD]  = 1'b0;                // R7
    // Stopped outputs keep level and enable; the output registers hold them
    if (stop_in)
    begin
      nxt_pout = pout_ff; // R9 R10
      nxt_poe  = poe_ff;  // R9 R10
    end
    else
    begin
      nxt_pout = (pctl_ff & s_out) | (~pctl_ff & pdat_ff); // R8
      nxt_poe  = (pctl_ff & s_oe)  | (~pctl_ff & pdir_ff); // R8
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pout_ff <= PIN_RST;
      poe_ff  <= PIN_RST; // R8
    end
    else
    begin
      pout_ff <= nxt_pout;
      poe_ff  <= nxt_poe;
    end
  end

  assign pin_out    = pout_ff;
  assign pin_oe_out = poe_ff;

endmodule : ssp_port0

// ===== ssp_port0_asserts.sv
// Checker bound to ssp_port0: bus answers, pin muxing and stop hold.
// Assumes pin configuration changes only through register writes.
`timescale 1ns/1ps
module ssp_port0_asserts
  import ssp_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              sys_rst_in,
  input  wire logic              stop_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  input  wire logic [DATA_W-1:0] reg_rdata_out,
  input  wire ssp_pins_t         pin_in,
  input  wire ssp_pins_t         pin_out,
  input  wire ssp_pins_t         pin_oe_out
);
  // ==========================================================
  // Configuration shadow
  logic [CTRL_W-1:0] ctrl_ff;
  logic [CTRL_W-1:0] nxt_ctrl;
  logic [PIN_W-1:0]  pctl_ff;
  logic [PIN_W-1:0]  nxt_pctl;
  logic [PIN_W-1:0]  pdir_ff;
  logic [PIN_W-1:0]  nxt_pdir;
  logic [PIN_W-1:0]  pdat_ff;
  logic [PIN_W-1:0]  nxt_pdat;
  logic [1:0]        quiet_ff;
  logic [1:0]        nxt_quiet;
  logic              gpio_ok;
  logic              ser_ok;

  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_pctl = pctl_ff;
    nxt_pdir = pdir_ff;
    nxt_pdat = pdat_ff;
    // Pins are registered, so judge them only once a write or stop has settled
    nxt_quiet = (reg_wr_in || stop_in) ? 2'h0 : quiet_ff + {1'b0, quiet_ff != 2'h3};
    if (reg_wr_in && reg_addr_in == REG_CTRL) nxt_ctrl = reg_wdata_in[CTRL_W-1:0];
    if (reg_wr_in && reg_addr_in == REG_PCTL) nxt_pctl = reg_wdata_in[PIN_W-1:0];
    if (reg_wr_in && reg_addr_in == REG_PDIR) nxt_pdir = reg_wdata_in[PIN_W-1:0];
    if (reg_wr_in && reg_addr_in == REG_PDAT) nxt_pdat = reg_wdata_in[PIN_W-1:0];
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      {ctrl_ff, pctl_ff, pdir_ff, pdat_ff, quiet_ff} <= '0;
    else
      {ctrl_ff, pctl_ff, pdir_ff, pdat_ff, quiet_ff} <=
        {nxt_ctrl, nxt_pctl, nxt_pdir, nxt_pdat, nxt_quiet};
  end

  assign gpio_ok = (quiet_ff == 2'h3) && !stop_in;
  assign ser_ok  = gpio_ok && ctrl_ff[CB_EN];

  // ==========================================================
  // Properties
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  property p_rd_idle;
    !reg_rd_in |=> reg_rdata_out == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_rxd_hi;
    reg_rd_in && reg_addr_in == REG_RXD |=> reg_rdata_out[DATA_W-1:WORD_LEN] == '0;
  endproperty
  a_rxd_hi: assert property (p_rxd_hi) else $error("rx word too wide");
  property p_stop_hold;
    stop_in |=> $stable(pin_out) && $stable(pin_oe_out);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("pins moved in stop");
  property p_gpio_dir;
    gpio_ok |-> ((pin_oe_out ^ pdir_ff) & ~pctl_ff) == '0;
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("port direction wrong");
  property p_gpio_out;
    gpio_ok |-> ((pin_out ^ pdat_ff) & pdir_ff & ~pctl_ff) == '0;
  endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("port level wrong");
  property p_fs_dir;
    ser_ok && pctl_ff[PIN_C] |-> pin_oe_out.serial_ctrl_line_c == ctrl_ff[CB_FS_OUT];
  endproperty
  a_fs_dir: assert property (p_fs_dir) else $error("frame sync direction");
  property p_clk_dir;
    ser_ok && pctl_ff[PIN_CLK] && pctl_ff[PIN_RXD] |->
      pin_oe_out.serial_bit_clock_pin == ctrl_ff[CB_CLK_OUT] && !pin_oe_out.serial_rx_data_pin;
  endproperty
  a_clk_dir: assert property (p_clk_dir) else $error("clock or rx direction");
  property p_a_dir;
    ser_ok && pctl_ff[PIN_A] |->
      pin_oe_out.serial_ctrl_line_a == (ctrl_ff[CB_SYNC] | ctrl_ff[CB_A_OUT]);
  endproperty
  a_a_dir: assert property (p_a_dir) else $error("line a direction");
  property p_flags;
    ser_ok && ctrl_ff[CB_SYNC] && ctrl_ff[CB_A_FLAG] && ctrl_ff[CB_B_FLAG] |->
      pin_out.serial_ctrl_line_a == ctrl_ff[CB_FLAG0] &&
      pin_out.serial_ctrl_line_b == ctrl_ff[CB_FLAG1];
  endproperty
  a_flags: assert property (p_flags) else $error("flag level wrong");
endmodule : ssp_port0_asserts

bind ssp_port0 ssp_port0_asserts u_asserts (
  .clock_in      (clock_in),
  .sys_rst_in    (sys_rst_in),
  .stop_in       (stop_in),
  .reg_addr_in   (reg_addr_in),
  .reg_wdata_in  (reg_wdata_in),
  .reg_wr_in     (reg_wr_in),
  .reg_rd_in     (reg_rd_in),
  .reg_rdata_out (reg_rdata_out),
  .pin_in        (pin_in),
  .pin_out       (pin_out),
  .pin_oe_out    (pin_oe_out)
);

// ===== ssp_far_end.sv
// Codec model at the far side of serial port zero.
// Assumes the pin carrier of ssp_port0; resolves each wire from both drivers.
`timescale 1ns/1ps
module ssp_far_end
  import ssp_pkg::*;
(
  input  wire logic      clock_in,
  input  wire logic      async_in,
  input  wire ssp_pins_t pin_out_in,
  input  wire ssp_pins_t pin_oe_in,
  output ssp_pins_t      pin_wire_out
);
  // ==========================================================
  // Line drivers
  logic       bclk  = 1'b0;
  logic       fsync = 1'b0;
  logic       rxd   = 1'b0;
  logic       busy  = 1'b0;
  logic       tog   = 1'b0;
  logic [7:0] got_a;
  logic [7:0] got_b;
  ssp_pins_t  drv;

  // Released lines a and b (outside async) and the idle receive data pin wander so a stale level never passes for data
  always @(posedge clock_in) tog <= ~tog;

  always_comb
  begin
    drv.serial_ctrl_line_a   = async_in ? bclk : tog;
    drv.serial_ctrl_line_b   = async_in ? fsync : ~tog;
    drv.serial_ctrl_line_c   = fsync;
    drv.serial_bit_clock_pin = bclk;
    drv.serial_rx_data_pin   = busy ? rxd : tog;
    pin_wire_out = ssp_pins_t'((pin_out_in & pin_oe_in) | (drv & ~pin_oe_in));
  end

  // ==========================================================
  // Frame: arming rise with sync high, eight bits MSB first
  task automatic send_frame(input logic [7:0] w);
    // Step off the system clock edge on which the caller returned
    #10;
    busy  = 1'b1;
    fsync = 1'b1;
    #400;
    for (int k = 0; k < 9; k++)
    begin
      if (k > 0) got_a[8-k] = pin_wire_out.serial_ctrl_line_a;
      if (k > 0) got_b[8-k] = pin_wire_out.serial_ctrl_line_b;
      #10 bclk = 1'b1;
      rxd = (k < 8) ? w[7-k] : ~w[0];
      #400 bclk = 1'b0;
      fsync = 1'b0;
      #390;
    end
    busy = 1'b0;
  endtask : send_frame
endmodule : ssp_far_end

// ===== tb_ssp_port0.sv
// Self-checking bench for ssp_port0 with a codec model on its pins.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ps
`define CHECK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module tb_ssp_port0;
  import ssp_pkg::*;
  logic              clock_in;
  logic              sys_rst_in;
  logic              stop_in;
  logic              async_mode;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [DATA_W-1:0] reg_wdata_in;
  logic              reg_wr_in;
  logic              reg_rd_in;
  logic [DATA_W-1:0] reg_rdata_out;
  ssp_pins_t         pin_in;
  ssp_pins_t         pin_out;
  ssp_pins_t         pin_oe_out;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] exp_v;
  logic              rd_pend = 1'b0;
  int                n_errors = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  int                seed;
  logic [31:0]       w;
  time               t0;
  logic [ADDR_W-1:0] ra[6] = '{REG_CTRL, REG_DIV, REG_PCTL, REG_PDIR, REG_STAT, 8'h24};

  ssp_port0 dut (
    .clock_in      (clock_in),
    .sys_rst_in    (sys_rst_in),
    .stop_in       (stop_in),
    .reg_addr_in   (reg_addr_in),
    .reg_wdata_in  (reg_wdata_in),
    .reg_wr_in     (reg_wr_in),
    .reg_rd_in     (reg_rd_in),
    .reg_rdata_out (reg_rdata_out),
    .pin_in        (pin_in),
    .pin_out       (pin_out),
    .pin_oe_out    (pin_oe_out)
  );

  ssp_far_end far (
    .clock_in     (clock_in),
    .async_in     (async_mode),
    .pin_out_in   (pin_out),
    .pin_oe_in    (pin_oe_out),
    .pin_wire_out (pin_in)
  );

  initial
  begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  // ==========================================================
  // Read answers and hang guard
  always @(posedge clock_in)
  begin
    cycles++;
    if (rd_pend)
    begin
      exp_v = exp_q.pop_front();
      `CHECK(reg_rdata_out, exp_v)
    end
    rd_pend <= reg_rd_in;
    if (cycles == 20000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic settle(input int n);
    repeat (n) @(posedge clock_in);
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_in);
    exp_q.push_back(e);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
  endtask : rd

  task end_of_test;
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Main sequence
  initial
  begin
    seed = 32'h76f6;
    {sys_rst_in, stop_in, async_mode, reg_wr_in, reg_rd_in} = 5'h10;
    reg_addr_in  = '0;
    reg_wdata_in = '0;
    repeat (6) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    foreach (ra[k]) rd(ra[k], (ra[k] == REG_DIV) ? 32'h4 : 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      w = $random(seed);
      if (k == 3) w[4:0] = 5'h1f;
      wr(REG_PDIR, {27'h0, w[4:0]});
      wr(REG_PDAT, {27'h0, w[9:5]});
      settle(4);
      `CHECK(pin_oe_out, w[4:0])
      `CHECK(pin_out & w[4:0], w[9:5] & w[4:0])
    end
    settle(2);
    rd(REG_PDAT, {27'h0, w[9:5]});
    stop_in <= 1'b1;
    wr(REG_PDAT, {27'h0, ~w[9:5]});
    settle(3);
    `CHECK(pin_out, w[9:5])
    stop_in <= 1'b0;
    // Synchronous mode, clock and frame sync from the codec
    w = $random(seed);
    wr(REG_PCTL, 32'h1f);
    wr(REG_TX1, {24'h0, w[7:0]});
    wr(REG_TX2, {24'h0, w[15:8]});
    wr(REG_CTRL, 32'h81);
    far.send_frame(w[23:16]);
    `CHECK(far.got_a, w[7:0])
    `CHECK(far.got_b, w[15:8])
    settle(8);
    rd(REG_STAT, 32'h1);
    rd(REG_RXD, {24'h0, w[23:16]});
    rd(REG_STAT, 32'h0);
    far.send_frame(w[7:0]);
    far.send_frame(w[15:8]);
    settle(8);
    rd(REG_STAT, 32'h3);
    rd(REG_RXD, {24'h0, w[15:8]});
    rd(REG_STAT, 32'h2);
    wr(REG_STAT, 32'h2);
    rd(REG_STAT, 32'h0);
    @(posedge clock_in);
    stop_in <= 1'b1;
    far.send_frame(~w[7:0]);
    @(posedge clock_in);
    stop_in <= 1'b0;
    settle(8);
    rd(REG_STAT, 32'h0);
    rd(REG_RXD, {24'h0, w[15:8]});
    for (int k = 1; k < 3; k++)
    begin
      wr(REG_CTRL, 32'h0e1 | (k << 8));
      settle(4);
      `CHECK(pin_out[1:0], 2'(k))
    end
    // Asynchronous mode: receive clock and sync on lines a and b
    wr(REG_CTRL, 32'h80);
    async_mode <= 1'b1;
    settle(4);
    far.send_frame(w[31:24]);
    settle(8);
    rd(REG_RXD, {24'h0, w[31:24]});
    async_mode <= 1'b0;
    // Internal clock below the floor of three cycles per half
    wr(REG_DIV, 32'h2);
    wr(REG_CTRL, 32'h87);
    @(posedge pin_out.serial_bit_clock_pin);
    t0 = $time;
    @(posedge pin_out.serial_bit_clock_pin);
    `CHECK(($time - t0) / 100, 64'd6)
    // Internal frame sync on line c lasts one bit period
    @(posedge pin_out.serial_ctrl_line_c);
    t0 = $time;
    @(negedge pin_out.serial_ctrl_line_c);
    `CHECK(($time - t0) / 100, 64'd6)
    // Asynchronous mode with receive clock and sync driven on lines a and b
    wr(REG_CTRL, 32'h98);
    settle(8);
    `CHECK(pin_oe_out, 5'h03)
    @(posedge pin_out.serial_ctrl_line_a);
    t0 = $time;
    @(posedge pin_out.serial_ctrl_line_a);
    `CHECK(($time - t0) / 100, 64'd6)
    settle(20);
    end_of_test();
  end
endmodule : tb_ssp_port0
